// file: vrs_consts.svh
`ifndef VRS_CONSTS_SVH
`define VRS_CONSTS_SVH
// ==========================================================
// reference format: 1 lsb = 6.25 mV, 8-bit code
`define VRS_REF_W          8
`define VRS_CLK_MHZ        200
`define VRS_STEP_KHZ       500
// step clock half period in mclk cycles (200 MHz / 500 kHz / 2)
`define VRS_STEP_HALF      ((`VRS_CLK_MHZ * 1000) / `VRS_STEP_KHZ / 2)
// serial ramp 3 mV/us: one 6.25 mV lsb per 2083 ns, rounded down
`define VRS_SVI_STEP_NS    2083
`define VRS_SVI_STEP_CYC   ((`VRS_SVI_STEP_NS * `VRS_CLK_MHZ) / 1000)
// soft-start 2.56 ms per volt: 16 us per 6.25 mV lsb
`define VRS_SS_STEP_NS     16000
`define VRS_SS_STEP_CYC    ((`VRS_SS_STEP_NS * `VRS_CLK_MHZ) / 1000)
`define VRS_REARM_CYC      16
// 0.5 V / 6.25 mV = 80 lsb
`define VRS_UV_ARM_CODE    8'h50
// droop gain code: 2'h1 means 1/4
`define VRS_DROOP_DEFAULT  2'h1
`define VRS_DPM_DELAY_CYC  64
`define VRS_FIX_STABLE_CYC 32
`endif

// file: vrs_pkg.sv
package vrs_pkg;
	typedef enum logic [1:0] {VRS_MODE_PVI, VRS_MODE_SVI, VRS_MODE_FIX} vrs_mode_t;
	typedef enum logic [2:0] {VRS_IDLE, VRS_SOFT, VRS_RUN, VRS_LATCH} vrs_state_t;
	typedef struct packed {
		logic uv_en;
		logic ov_en;
		logic pg_en;
		logic fb_en;
		logic oc_en;
	} vrs_prot_t;
	typedef struct packed {
		logic [1:0] pwm_out;
		logic [1:0] pwm_oe;
		logic       drv_en;
	} vrs_drv_t;
endpackage : vrs_pkg

// file: vrs_ramp.sv
`timescale 1ns/10ps
`include "vrs_consts.svh"
// ==========================================================
// one section reference ramp: steps one lsb toward target per tick
module vrs_ramp #(
	parameter int REF_W = `VRS_REF_W
) (
	input  wire logic             mclk,
	input  wire logic             reset_n,
	input  wire logic             clk_en,
	input  wire logic             clear,
	input  wire logic             tick,
	input  wire logic [REF_W-1:0] target,
	output logic      [REF_W-1:0] ref_code,
	output logic                  at_target
);
	typedef struct packed {
		logic [REF_W-1:0] ref_code;
	} vrs_ramp_st_t;
	vrs_ramp_st_t st;
	vrs_ramp_st_t next_st;

	// step up or down, hold once equal
	always_comb begin
		next_st = st;
		if (clear) begin
			next_st.ref_code = '0;
		end else if (tick && st.ref_code < target) begin
			next_st.ref_code = st.ref_code + 1'b1;
		end else if (tick && st.ref_code > target) begin
			next_st.ref_code = st.ref_code - 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign ref_code  = st.ref_code;
	assign at_target = (st.ref_code == target);
endmodule : vrs_ramp

// file: vrs_sequencer.sv
`timescale 1ns/10ps
`include "vrs_consts.svh"
// Summary of operation
// - mask ov, uv and power good during each transition, re-arm 16 cycles later
// - overcurrent during a transition latches the device disabled
// - parallel mode samples vid on step clock rise, confirms on fall
// - after confirmation, next rise starts stepping one lsb every two step cycles
// - vid changes ignored during transition, monitoring resumes on next rise
// - larger changes keep stepping one lsb every two step cycles until code reached
// - serial command ramps affected section reference at about 3 mV/us
// - new serial command mid-ramp replaces target, ramp continues
// - start-up vid captured at enable, later changes not tracked
// - fixed mode watches serial pins, stable code ramps both sections
// - soft-start only with supply above lockout and enable released
// - power good released only when digital soft-start completes
// - undervoltage detection enabled once reference reaches 0.5 V
// - overvoltage and feedback-disconnect detection stay active in soft-start
// - soft-start slope fixed at 2.56 ms per volt
// - pwm high impedance and driver enable low until first pwm pulse
// - after first pulse pwm drives low and high, driver enable high
// - low-side suppression is loop only; overvoltage protection may still force it
// - north-bridge droop gain defaults to 1/4, changed only by bus command
// - manager bus disabled by strap keeps droop gain at default
// - phase manager reset during cpu transitions, re-enabled after a delay
// - overcurrent protection stays active while others are masked
module vrs_sequencer #(
	parameter int REF_W       = `VRS_REF_W,
	parameter int SS_STEP_CYC = `VRS_SS_STEP_CYC
) (
	input  wire logic               mclk,
	input  wire logic               reset_n,
	input  wire logic               clk_en,
	input  wire logic               supply_ok,
	input  wire logic               enable_in,
	input  vrs_pkg::vrs_mode_t      mode,
	input  wire logic [REF_W-1:0]   parallel_vid_in,
	input  wire logic [REF_W-1:0]   startup_vid_core,
	input  wire logic [REF_W-1:0]   startup_vid_nb,
	input  wire logic               svi_cmd_valid,
	input  wire logic [1:0]         svi_cmd_sel,
	input  wire logic [REF_W-1:0]   svi_cmd_vid,
	input  wire logic [REF_W-1:0]   fix_pin_code,
	input  wire logic               overcurrent,
	input  wire logic               overvoltage,
	input  wire logic               first_pwm_pulse,
	input  wire logic [1:0]         loop_pwm,
	input  wire logic               manager_bus_disable_strap,
	input  wire logic               droop_gain_command,
	input  wire logic [1:0]         droop_gain_value,
	output logic [REF_W-1:0]        core_ref,
	output logic [REF_W-1:0]        nb_ref,
	output vrs_pkg::vrs_prot_t      prot_en,
	output vrs_pkg::vrs_drv_t       drv,
	output logic                    power_good_out,
	output logic                    on_the_fly_vid_change,
	output logic                    dynamic_phase_manager_en,
	output logic [1:0]              nb_droop_gain,
	output logic                    fault_latched,
	output logic                    vid_step_clock
);
	import vrs_pkg::*;

	localparam int STEP_HALF = `VRS_STEP_HALF;
	localparam int SVI_CYC   = `VRS_SVI_STEP_CYC;

	typedef struct packed {
		vrs_state_t       state;
		logic [7:0]       step_div;
		logic             step_clk;
		logic             step_phase;
		logic [1:0]       pvi_st;
		logic [REF_W-1:0] pvi_sample;
		logic [REF_W-1:0] core_tgt;
		logic [REF_W-1:0] nb_tgt;
		logic [15:0]      rate_cnt;
		logic [4:0]       rearm_cnt;
		logic             masked;
		logic             uv_armed;
		logic             pg;
		logic             switching;
		logic             ov_trip;
		logic [1:0]       droop;
		logic [6:0]       dpm_cnt;
		logic [REF_W-1:0] fix_last;
		logic [5:0]       fix_cnt;
	} vrs_st_t;

	vrs_st_t st;
	vrs_st_t next_st;

	logic [REF_W-1:0] core_ref_w;
	logic [REF_W-1:0] nb_ref_w;
	logic             core_at;
	logic             nb_at;
	logic             ramp_clear;
	logic             ramp_tick;
	logic             step_rise;
	logic             step_fall;
	logic             in_transition;
	logic             mask_now;

	// ==========================================================
	// reference ramps
	vrs_ramp #(.REF_W(REF_W)) u_core (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.clear     (ramp_clear),
		.tick      (ramp_tick),
		.target    (st.core_tgt),
		.ref_code  (core_ref_w),
		.at_target (core_at)
	);
	vrs_ramp #(.REF_W(REF_W)) u_nb (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.clear     (ramp_clear),
		.tick      (ramp_tick),
		.target    (st.nb_tgt),
		.ref_code  (nb_ref_w),
		.at_target (nb_at)
	);

	// the divider runs in every state, so the step phase never jumps on a mode change
	// step clock edges come from the internal divider, so no crossing is needed
	assign step_rise     = (st.step_div == 8'(STEP_HALF - 1)) && !st.step_clk;
	assign step_fall     = (st.step_div == 8'(STEP_HALF - 1)) && st.step_clk;
	assign in_transition = (st.state == VRS_RUN) && !(core_at && nb_at);
	// the mask covers the first transition cycle too, before the register catches up
	assign mask_now      = st.masked || in_transition;
	assign ramp_clear    = (st.state == VRS_IDLE) || (st.state == VRS_LATCH);

	// ==========================================================
	// rate selection for the ramps
	// one counter serves both sections, so they always step on the same edge
	always_comb begin
		ramp_tick = 1'b0;
		if (st.state == VRS_SOFT) begin
			ramp_tick = (st.rate_cnt == 16'(SS_STEP_CYC - 1));
		end else if (st.state == VRS_RUN) begin
			if (mode == VRS_MODE_PVI) begin
				// one lsb every two step cycles, on a rising edge
				ramp_tick = step_rise && st.step_phase;
			end else begin
				ramp_tick = (st.rate_cnt == 16'(SVI_CYC - 1));
			end
		end
	end

	// ==========================================================
	// next state
	always_comb begin
		next_st = st;
		// step clock divider
		if (st.step_div == 8'(STEP_HALF - 1)) begin
			next_st.step_div = '0;
			next_st.step_clk = !st.step_clk;
		end else begin
			next_st.step_div = st.step_div + 8'h01;
		end
		if (step_rise) begin
			next_st.step_phase = !st.step_phase;
		end
		// shared rate counter; restarts on each tick
		if (ramp_tick || !(st.state == VRS_SOFT || in_transition)) begin
			next_st.rate_cnt = '0;
		end else begin
			next_st.rate_cnt = st.rate_cnt + 16'h0001;
		end
		// droop gain: only the bus may change it, never with the strap set
		// the strap wins over a command that lands in the same cycle
		if (manager_bus_disable_strap) begin
			next_st.droop = `VRS_DROOP_DEFAULT;
		end else if (droop_gain_command) begin
			next_st.droop = droop_gain_value;
		end
		if (!st.switching && first_pwm_pulse && st.state != VRS_IDLE) begin
			next_st.switching = 1'b1;
		end
		unique case (st.state)
			VRS_IDLE: begin
				next_st.pg        = 1'b0;
				next_st.switching = 1'b0;
				next_st.uv_armed  = 1'b0;
				// level start: every latch or lockout passes through here, so no edge is needed
				if (supply_ok && enable_in) begin
					// startup values captured once at enable
					next_st.core_tgt = startup_vid_core;
					next_st.nb_tgt   = startup_vid_nb;
					next_st.state    = VRS_SOFT;
				end
			end
			VRS_SOFT: begin
				if (core_ref_w >= `VRS_UV_ARM_CODE) begin
					next_st.uv_armed = 1'b1;
				end
				if (core_at && nb_at) begin
					next_st.pg       = 1'b1;
					next_st.uv_armed = 1'b1;
					next_st.state    = VRS_RUN;
					next_st.pvi_st   = 2'h0;
				end
			end
			VRS_RUN: begin
				unique case (mode)
					VRS_MODE_PVI: begin
						// 0 watch, 1 confirm on fall, 2 start on next rise
						if (st.pvi_st == 2'h0 && step_rise && !in_transition) begin
							if (parallel_vid_in != st.core_tgt) begin
								next_st.pvi_sample = parallel_vid_in;
								next_st.pvi_st     = 2'h1;
							end
						end else if (st.pvi_st == 2'h1 && step_fall) begin
							next_st.pvi_st = (parallel_vid_in == st.pvi_sample) ? 2'h2 : 2'h0;
						end else if (st.pvi_st == 2'h2 && step_rise) begin
							next_st.core_tgt   = st.pvi_sample;
							next_st.step_phase = 1'b1;
							next_st.pvi_st     = 2'h0;
						end
					end
					VRS_MODE_SVI: begin
						// a new command simply overwrites the target mid-ramp
						if (svi_cmd_valid && svi_cmd_sel[0]) begin
							next_st.core_tgt = svi_cmd_vid;
						end
						if (svi_cmd_valid && svi_cmd_sel[1]) begin
							next_st.nb_tgt = svi_cmd_vid;
						end
					end
					VRS_MODE_FIX: begin
						// code must hold steady before it is taken
						if (fix_pin_code != st.fix_last) begin
							next_st.fix_last = fix_pin_code;
							next_st.fix_cnt  = '0;
						end else if (st.fix_cnt != 6'(`VRS_FIX_STABLE_CYC)) begin
							next_st.fix_cnt = st.fix_cnt + 6'h01;
						end else if (fix_pin_code != st.core_tgt) begin
							next_st.core_tgt = fix_pin_code;
							next_st.nb_tgt   = fix_pin_code;
						end
					end
					default: begin
					end
				endcase
				if (overcurrent && in_transition) begin
					next_st.state = VRS_LATCH;
				end
			end
			VRS_LATCH: begin
				next_st.pg = 1'b0;
				// disabled: both sections go high impedance unless ov holds the low side on
				next_st.switching = 1'b0;
			end
		endcase
		// over-voltage latch from any active state
		// gated by the live ov enable, so a masked transition cannot trip it
		if (overvoltage && prot_en.ov_en && st.state != VRS_IDLE) begin
			next_st.ov_trip = 1'b1;
			next_st.state   = VRS_LATCH;
		end
		// ==========================================================
		// masking and re-arm; restart while a transition is still running
		// overcurrent is never gated here; only ov, uv and power good follow the mask
		if (in_transition) begin
			next_st.masked    = 1'b1;
			next_st.rearm_cnt = '0;
			next_st.dpm_cnt   = '0;
		end else if (st.masked) begin
			if (st.rearm_cnt == 5'(`VRS_REARM_CYC - 1)) begin
				next_st.masked = 1'b0;
			end else begin
				next_st.rearm_cnt = st.rearm_cnt + 5'h01;
			end
		end
		// phase manager stays off until the delay has run out after each transition
		if (!in_transition && st.dpm_cnt != 7'(`VRS_DPM_DELAY_CYC)) begin
			next_st.dpm_cnt = st.dpm_cnt + 7'h01;
		end
		// lockout or enable drop returns to idle from anywhere
		if (!supply_ok || !enable_in) begin
			next_st.state     = VRS_IDLE;
			next_st.ov_trip   = 1'b0;
			next_st.masked    = 1'b0;
			next_st.rearm_cnt = '0;
			next_st.pvi_st    = 2'h0;
		end
	end

	// ==========================================================
	// state register, frozen while the clock enable is low
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st       <= '0;
			st.droop <= `VRS_DROOP_DEFAULT;
			st.state <= VRS_IDLE;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// ==========================================================
	// outputs
	// enables decode state and the live mask, so they lag a transition by no cycle
	always_comb begin
		prot_en.oc_en = (st.state == VRS_SOFT) || (st.state == VRS_RUN);
		prot_en.fb_en = prot_en.oc_en;
		prot_en.ov_en = (st.state == VRS_SOFT) || (st.state == VRS_RUN && !mask_now);
		prot_en.uv_en = st.uv_armed && !mask_now && prot_en.oc_en;
		prot_en.pg_en = (st.state == VRS_RUN) && !mask_now;
	end

	// drivers: high-z until switching starts; ov trip forces low-side on
	// a latched overcurrent clears switching, so that path ends in high impedance
	always_comb begin
		if (st.ov_trip) begin
			drv.pwm_out = 2'h0;
			drv.pwm_oe  = 2'h3;
			drv.drv_en  = 1'b1;
		end else if (st.switching) begin
			drv.pwm_out = loop_pwm;
			drv.pwm_oe  = 2'h3;
			drv.drv_en  = 1'b1;
		end else begin
			drv.pwm_out = 2'h0;
			drv.pwm_oe  = 2'h0;
			drv.drv_en  = 1'b0;
		end
	end

	assign core_ref                 = core_ref_w;
	assign nb_ref                   = nb_ref_w;
	// masking freezes the power good monitor; it never pulls the pin low itself
	assign power_good_out           = st.pg;
	assign on_the_fly_vid_change    = in_transition;
	assign dynamic_phase_manager_en = st.pg && !in_transition
	                                  && (st.dpm_cnt == 7'(`VRS_DPM_DELAY_CYC));
	assign nb_droop_gain            = st.droop;
	assign fault_latched            = (st.state == VRS_LATCH);
	assign vid_step_clock           = st.step_clk;
endmodule : vrs_sequencer

// file: vrs_sequencer_chk.sv
`timescale 1ns/10ps
`include "vrs_consts.svh"
// ==========================================================
// port checks of the reference sequencer
module vrs_chk
	import vrs_pkg::*;
#(
	parameter int REF_W       = 8,
	parameter int SS_STEP_CYC = 4
) (
	input wire logic             mclk,
	input wire logic             reset_n,
	input wire logic             enable_in,
	input wire logic             supply_ok,
	input wire logic             overcurrent,
	input wire logic             overvoltage,
	input wire logic             droop_gain_command,
	input wire logic             manager_bus_disable_strap,
	input wire logic [REF_W-1:0] core_ref,
	input wire logic [REF_W-1:0] nb_ref,
	input vrs_pkg::vrs_prot_t    prot_en,
	input vrs_pkg::vrs_drv_t     drv,
	input wire logic             power_good_out,
	input wire logic             on_the_fly_vid_change,
	input wire logic [1:0]       nb_droop_gain,
	input wire logic             fault_latched
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// ==========================================================
	// protection masking around transitions
	a_mask_otf: assert property (on_the_fly_vid_change |-> !prot_en.ov_en && !prot_en.uv_en)
		else $error("monitor armed during transition");
	a_pg_masked: assert property (on_the_fly_vid_change |-> !prot_en.pg_en)
		else $error("power good monitor armed during transition");
	a_oc_kept: assert property (on_the_fly_vid_change |-> prot_en.oc_en)
		else $error("overcurrent masked during transition");
	// fifteen masked cycles at least after the transition ends
	a_rearm_wait: assert property ($fell(on_the_fly_vid_change) |-> (!prot_en.ov_en)[*8] ##1 (!prot_en.ov_en)[*7])
		else $error("monitor re-armed too early");
	// ==========================================================
	// faults and their latch
	a_oc_latch: assert property (overcurrent && on_the_fly_vid_change |-> ##[1:4] fault_latched)
		else $error("overcurrent in transition not latched");
	a_latch_hold: assert property (fault_latched && enable_in && supply_ok |=> fault_latched)
		else $error("latch left without enable cycle");
	a_idle_zero: assert property ((!enable_in)[*3] |-> core_ref == 8'h00 && !power_good_out)
		else $error("reference not idle while disabled");
	a_ov_low_side: assert property (overvoltage && prot_en.ov_en |-> ##[1:4] (fault_latched && drv.drv_en && drv.pwm_out == 2'h0))
		else $error("overvoltage did not turn low side on");
	// ==========================================================
	// driver sequence and soft-start arming
	a_hiz_start: assert property (!drv.drv_en |-> drv.pwm_oe == 2'h0)
		else $error("pwm driven while drivers disabled");
	a_drive_run: assert property (drv.drv_en && !fault_latched |-> drv.pwm_oe == 2'h3)
		else $error("pwm not driven while drivers enabled");
	a_uv_arm: assert property (prot_en.uv_en && !power_good_out && !fault_latched |-> core_ref >= `VRS_UV_ARM_CODE)
		else $error("undervoltage armed below threshold");
	// ==========================================================
	// droop gain: the strap held means the default, else only a command moves it
	a_gain_strap: assert property (manager_bus_disable_strap && $past(manager_bus_disable_strap) |-> nb_droop_gain == `VRS_DROOP_DEFAULT)
		else $error("droop gain moved with bus strapped off");
	a_gain_cmd: assert property ($changed(nb_droop_gain) |-> $past(droop_gain_command) || $past(droop_gain_command, 2))
		else $error("droop gain moved without command");
endmodule : vrs_chk

bind vrs_sequencer vrs_chk #(.REF_W(REF_W), .SS_STEP_CYC(SS_STEP_CYC)) chk_u (
	.mclk(mclk), .reset_n(reset_n), .enable_in(enable_in), .supply_ok(supply_ok),
	.overcurrent(overcurrent), .overvoltage(overvoltage), .droop_gain_command(droop_gain_command),
	.manager_bus_disable_strap(manager_bus_disable_strap), .core_ref(core_ref), .nb_ref(nb_ref),
	.prot_en(prot_en), .drv(drv), .power_good_out(power_good_out),
	.on_the_fly_vid_change(on_the_fly_vid_change), .nb_droop_gain(nb_droop_gain),
	.fault_latched(fault_latched)
);

// file: vrs_partner.sv
`timescale 1ns/10ps
// ==========================================================
// loop and driver stand-in: one first pulse per start-up
module vrs_partner #(
	parameter int REF_W = 8
) (
	input  wire logic             mclk,
	input  wire logic             reset_n,
	input  wire logic [REF_W-1:0] core_ref,
	output logic                  first_pwm_pulse,
	output logic [1:0]            loop_pwm
);
	logic fired;
	// pulse once the reference reaches code 4; re-arms when it falls below 4
	// the loop pattern changes every cycle so a stale copy is visible
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			fired           <= 1'b0;
			first_pwm_pulse <= 1'b0;
			loop_pwm        <= 2'h0;
		end else begin
			fired           <= (core_ref >= 8'h04);
			first_pwm_pulse <= (core_ref >= 8'h04) && !fired;
			loop_pwm        <= loop_pwm + 2'h1;
		end
	end
endmodule : vrs_partner

// file: vrs_sequencer_tb_top.sv
`timescale 1ns/10ps
`include "vrs_consts.svh"
// ==========================================================
// start-up, transitions in every mode, faults, droop gain
module vrs_sequencer_tb_top;
	import vrs_pkg::*;
	localparam int SS   = 4;
	localparam int STEP = 2 * `VRS_STEP_HALF;
	logic       mclk, reset_n, supply_ok, enable_in, cmd_v, oc, ov, strap, dcmd;
	logic       pg, otf, pm_en, fault, step_clk, pulse;
	logic [1:0] gval, lpwm, gain;
	logic [7:0] pvid, st_c, st_n, svid, fix, core_ref, nb_ref, t1, t2;
	vrs_mode_t  mode;
	vrs_prot_t  prot;
	vrs_drv_t   drv;
	int         num_errors, checks_done, cyc, n;

	vrs_sequencer #(.SS_STEP_CYC(SS)) dut_u (.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1),
		.supply_ok(supply_ok), .enable_in(enable_in), .mode(mode), .parallel_vid_in(pvid),
		.startup_vid_core(st_c), .startup_vid_nb(st_n), .svi_cmd_valid(cmd_v),
		.svi_cmd_sel(2'h3), .svi_cmd_vid(svid), .fix_pin_code(fix), .overcurrent(oc),
		.overvoltage(ov), .first_pwm_pulse(pulse), .loop_pwm(lpwm),
		.manager_bus_disable_strap(strap), .droop_gain_command(dcmd), .droop_gain_value(gval),
		.core_ref(core_ref), .nb_ref(nb_ref), .prot_en(prot), .drv(drv), .power_good_out(pg),
		.on_the_fly_vid_change(otf), .dynamic_phase_manager_en(pm_en), .nb_droop_gain(gain),
		.fault_latched(fault), .vid_step_clock(step_clk));
	vrs_partner part_u (.mclk(mclk), .reset_n(reset_n), .core_ref(core_ref),
		.first_pwm_pulse(pulse), .loop_pwm(lpwm));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// hang guard, well above the longest sequence
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tick(int k);
		repeat (k) @(negedge mclk);
	endtask : tick
	// bounded waits: reference at a code, reference moves, transition flag up
	task automatic wait_ref(logic [7:0] t, int lim, output int c);
		c = 0;
		while (core_ref !== t && c < lim) begin
			tick(1);
			c++;
		end
	endtask : wait_ref
	task automatic wait_move(output int c);
		logic [7:0] was;
		was = core_ref;
		c = 0;
		while (core_ref === was && c < 4000) begin
			tick(1);
			c++;
		end
	endtask : wait_move
	task automatic wait_otf();
		int c;
		c = 0;
		while (otf !== 1'b1 && c < 8 * STEP) begin
			tick(1);
			c++;
		end
	endtask : wait_otf
	task automatic pulse_in(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(4);
	endtask : pulse_in
	task automatic do_reset(logic s);
		reset_n = 1'b0;
		strap = s;
		enable_in = 1'b0;
		tick(3);
		reset_n = 1'b1;
	endtask : do_reset

	initial begin
		{num_errors, checks_done, cyc} = '0;
		{supply_ok, cmd_v, oc, ov, dcmd} = '0;
		mode = VRS_MODE_PVI;
		{gval, svid, fix} = '0;
		n = $urandom(32'h4AED);
		st_c = 8'h60 + 8'($urandom % 32);
		st_n = st_c + 8'($urandom % 4);
		pvid = st_c;
		do_reset(1'b0);
		// parallel start-up, held off by lockout first
		chk("gain default", 8'(`VRS_DROOP_DEFAULT), 8'(gain));
		enable_in = 1'b1;
		tick(40);
		chk("ref in lockout", 8'h00, core_ref);
		chk("hiz before pulse", 8'h00, 8'({drv.pwm_oe, drv.drv_en}));
		supply_ok = 1'b1;
		tick(st_c * SS / 2);
		chk("pg mid ramp", 8'h00, 8'(pg));
		chk("uv below half volt", 8'h00, 8'(prot.uv_en));
		chk("ov in soft-start", 8'h01, 8'(prot.ov_en));
		wait_ref(st_c, st_c * SS + 200, n);
		chk("soft-start end", st_c, core_ref);
		chk("soft-start time", 8'h01, 8'(n >= st_c * SS / 2 - SS && n <= st_c * SS / 2 + 64));
		tick(40);
		chk("pg after ramp", 8'h01, 8'(pg));
		chk("drivers enabled", 8'h07, 8'({drv.pwm_oe, drv.drv_en}));
		chk("pwm follows loop", 8'(lpwm), 8'(drv.pwm_out));
		gval = 2'h3;
		pulse_in(dcmd);
		chk("gain by command", 8'h03, 8'(gain));
		// step clock high time
		@(posedge step_clk);
		// start one falling edge after the rise, so n counts whole high cycles
		tick(1);
		n = 0;
		while (step_clk === 1'b1 && n < 1000) begin
			tick(1);
			n++;
		end
		chk("step half", 8'(`VRS_STEP_HALF), 8'(n));
		// parallel change, and a second change ignored until it ends
		t1 = st_c + 8'h03;
		t2 = st_c - 8'h02;
		pvid = t1;
		wait_otf();
		chk("phase mgr reset", 8'h00, 8'(pm_en));
		chk("transition flag", 8'h01, 8'(otf));
		pvid = t2;
		wait_ref(t1, 8 * STEP, n);
		chk("first target", t1, core_ref);
		chk("parallel slew", 8'h01, 8'(n >= 2 * STEP));
		wait_ref(t2, 16 * STEP, n);
		chk("resumed target", t2, core_ref);
		tick(70);
		chk("rearmed", 8'h01, 8'(prot.ov_en));
		chk("phase mgr back", 8'h01, 8'(pm_en));
		// serial start-up with bus strapped off
		do_reset(1'b1);
		mode = VRS_MODE_SVI;
		enable_in = 1'b1;
		wait_ref(st_c, st_c * SS + 200, n);
		tick(40);
		chk("core start", st_c, core_ref);
		chk("nb start", st_n, nb_ref);
		st_c = st_c ^ 8'h08;
		tick(60);
		chk("start vid kept", st_c ^ 8'h08, core_ref);
		gval = 2'h2;
		pulse_in(dcmd);
		chk("gain strapped", 8'(`VRS_DROOP_DEFAULT), 8'(gain));
		// serial command, then a replacement target mid-ramp
		svid = core_ref + 8'h04;
		pulse_in(cmd_v);
		wait_move(n);
		wait_move(n);
		chk("serial slope", 8'h01, 8'(n >= `VRS_SVI_STEP_CYC - 16 && n <= `VRS_SVI_STEP_CYC + 16));
		svid = core_ref - 8'h01;
		t2 = svid;
		pulse_in(cmd_v);
		wait_ref(t2, 6000, n);
		tick(2000);
		chk("new target core", t2, core_ref);
		chk("new target nb", t2, nb_ref);
		// overcurrent inside a transition
		svid = core_ref + 8'h06;
		pulse_in(cmd_v);
		wait_otf();
		pulse_in(oc);
		chk("oc latch", 8'h01, 8'(fault));
		tick(30);
		chk("latch held", 8'h01, 8'(fault));
		enable_in = 1'b0;
		tick(8);
		chk("latch cleared", 8'h00, 8'(fault));
		chk("idle ref", 8'h00, core_ref);
		// fixed mode: pin code change moves both sections
		mode = VRS_MODE_FIX;
		// both sections start from one code, so a pin change moves them in step
		st_c = st_n;
		fix = st_n + 8'h01 + 8'($urandom % 4);
		enable_in = 1'b1;
		// soft-start, the stable wait and up to four serial-rate steps
		wait_ref(fix, fix * SS + 4 * `VRS_SVI_STEP_CYC + 400, n);
		tick(100);
		fix = fix + 8'h02;
		wait_ref(fix, 3000, n);
		tick(50);
		chk("fixed core", fix, core_ref);
		chk("fixed nb", fix, nb_ref);
		// overvoltage during soft-start still turns the low side on
		enable_in = 1'b0;
		tick(8);
		enable_in = 1'b1;
		tick(20 * SS);
		pulse_in(ov);
		chk("ov latch", 8'h01, 8'(fault));
		chk("ov low side", 8'h01, 8'(drv.drv_en && drv.pwm_out === 2'h0));
		finish_test();
	end
endmodule : vrs_sequencer_tb_top
